// *** src/sft_pkg.sv ***
// constants, register map and types shared by the single-edge nibble transmitter
// assumes a 40 MHz system clock; the 4 MHz tick reference is derived from it
package sft_pkg;
   // ----------------------------------------------------------------
   // clocking and tick range
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int REF_HZ = 4_000_000;
   localparam int REF_DIV = CLK_HZ / REF_HZ;
   localparam int TICK_MIN_NS = 250;
   localparam int TICK_MAX_NS = 31750;
   localparam int DIV_MAX = TICK_MAX_NS / TICK_MIN_NS;
   localparam int DIV_W = $clog2(DIV_MAX + 1);
   localparam int TCNT_W = $clog2(REF_DIV * DIV_MAX + 1);
   // ----------------------------------------------------------------
   // frame geometry in ticks
   // ----------------------------------------------------------------
   localparam int NIB_W = 4;
   localparam int SYNC_TICKS = 56;
   localparam int VAR_BASE = 7;
   localparam int NIB_MAX = 15;
   localparam int PAUSE_MIN = 12;
   localparam int DATA_MIN = 3;
   localparam int DATA_MAX = 6;
   localparam int DATA_W = NIB_W * DATA_MAX;
   localparam int LEN_W = 10;
   localparam int IDX_W = 3;
   localparam logic [3:0] CRC_SEED = 4'h5;
   localparam logic [63:0] CRC_TAB = 64'h582f_b6c1_493e_a7d0;
   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TIMING = 8'h04;
   localparam logic [7:0] REG_FRAME = 8'h08;
   localparam logic [7:0] REG_DATA = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_TRIG = 8'h14;
   localparam int CTRL_TRIG_BIT = 0;
   localparam int CTRL_INV_BIT = 1;
   localparam int CTRL_FIXSEL_BIT = 2;
   localparam int CTRL_PAUSE_BIT = 3;
   localparam int CTRL_PROTO_LSB = 4;
   localparam int TIM_DIV_LSB = 0;
   localparam int TIM_FIX_LSB = 8;
   localparam int FRM_STAT_LSB = 0;
   localparam int FRM_SER_LSB = 2;
   localparam int FRM_CNT_LSB = 4;
   localparam int TRIG_BIT = 0;
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_PEND_BIT = 1;
   localparam int STS_LINE_BIT = 2;
   localparam int STS_FCNT_LSB = 16;
   localparam logic [31:0] CTRL_MASK = 32'h0000_003f;
   localparam logic [31:0] TIM_MASK = 32'h0000_0f7f;
   localparam logic [31:0] FRM_MASK = 32'h0000_007f;
   localparam logic [31:0] DATA_MASK = 32'h00ff_ffff;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] TIM_RST = 32'h0000_050c;
   localparam logic [31:0] FRM_RST = 32'h0000_0060;
   localparam logic [1:0] PROTO_SENT = 2'h0;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SYNC = 3'h1,
      ST_STAT = 3'h2,
      ST_DATA = 3'h3,
      ST_CRC = 3'h4,
      ST_PAUSE = 3'h5
   } sft_state_t;

   typedef struct packed {
      logic invert;
      logic fixsel;
      logic pause;
      logic [3:0] fixed;
      logic [IDX_W-1:0] ndata;
      logic [1:0] status;
      logic [1:0] serial;
      logic [DATA_W-1:0] data;
   } sft_snap_t;
endpackage : sft_pkg

// *** src/sft_tick_gen.sv ***
// tick pulse generator: system clock to 4 MHz reference, then the programmed divider
// assumes a divider value that is stable while frames run
`timescale 1ns/1ps
module sft_tick_gen
   import sft_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic [DIV_W-1:0] div_in,
   output logic tick_out
);
   typedef struct packed {
      logic [TCNT_W-1:0] cnt;
      logic tick;
   } sft_tick_st_t;

   sft_tick_st_t st_q;
   sft_tick_st_t st_d;
   logic [DIV_W-1:0] div_eff;
   logic [TCNT_W-1:0] term;

   always_comb begin
      st_d = st_q;
      // divider 0 runs as 1
      div_eff = (div_in == '0) ? DIV_W'(1) : div_in;
      term = TCNT_W'(REF_DIV * int'(div_eff) - 1);
      st_d.tick = 1'b0;
      if (st_q.cnt >= term) begin
         st_d.cnt = '0;
         st_d.tick = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + TCNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick_out = st_q.tick;
endmodule : sft_tick_gen

// *** src/sft_crc.sv ***
// four-bit checksum over the data nibbles, most significant nibble first
// assumes the nibble count is already clamped to its legal range
`timescale 1ns/1ps
module sft_crc
   import sft_pkg::*;
(
   input wire logic [DATA_W-1:0] data_in,
   input wire logic [IDX_W-1:0] count_in,
   output logic [NIB_W-1:0] crc_out
);
   logic [NIB_W-1:0] chain [DATA_MAX+1];
   logic [NIB_W-1:0] pick;

   assign chain[0] = CRC_SEED;

   genvar i;
   generate
      for (i = 0; i < DATA_MAX; i++) begin : g_stage
         assign chain[i+1] = data_in[NIB_W*(DATA_MAX-1-i) +: NIB_W]
            ^ CRC_TAB[NIB_W*int'(chain[i]) +: NIB_W];
      end
   endgenerate

   always_comb begin
      pick = chain[count_in];
      // closing zero nibble
      crc_out = CRC_TAB[NIB_W*int'(pick) +: NIB_W];
   end
endmodule : sft_crc

// *** src/sft_transmitter.sv ***
// single-edge nibble transmitter with an Avalon-MM register slave
// assumes trig_in comes from a pin and sent_out drives the line buffer
//
// Contract
// - tick period is the 4 MHz reference divided by the programmed divider.
// - divider covers tick periods from 0.25 us to 31.75 us.
// - each nibble is a low interval then a high interval, summed.
// - settings choose which interval is fixed and its length.
// - variable interval is seven ticks plus the nibble value.
// - frame order is sync, status, data, checksum, optional pause.
// - sync nibble lasts exactly 56 ticks.
// - status nibble bits 1:0 carry the device status setting.
// - status nibble bits 3:2 carry the serial protocol setting.
// - three to six data nibbles, count and content from settings.
// - one checksum nibble follows the data, over the data nibbles.
// - pause, when sent, lasts at least 12 ticks and pads the frame.
// - by default frames go out back to back without request.
// - in trigger state exactly one frame is sent per trigger; triggers arriving while a frame is pending merge into it.
// - an option inverts the output polarity.
// - output protocol selection resets to 0, which selects nibble framing.
// - most significant data nibble first; 12-bit value in first three.
// - pause selection 0 appends no pause, frame length follows content.
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sft_transmitter
   import sft_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic trig_in,
   output logic sent_out
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] timing;
      logic [31:0] frame;
      logic [31:0] data;
      logic ack;
      logic [31:0] rdata;
      logic sy1;
      logic sy2;
      logic sy3;
      logic pend;
      sft_state_t state;
      logic [LEN_W-1:0] cnt;
      logic [LEN_W-1:0] elapsed;
      logic [LEN_W-1:0] pause_len;
      logic [IDX_W-1:0] idx;
      sft_snap_t snap;
      logic line;
      logic [15:0] fcnt;
   } sft_tx_st_t;

   sft_tx_st_t st_q;
   sft_tx_st_t st_d;

   logic tick;
   logic [NIB_W-1:0] crc;
   logic [31:0] be_mask;
   logic [31:0] wmerge;
   logic req;
   logic wr_now;
   logic trig_edge;
   logic can_start;
   logic start_now;
   logic last_tick;
   logic [NIB_W-1:0] nib_val;
   logic [LEN_W-1:0] fix_eff;
   logic [LEN_W-1:0] tot;
   logic [LEN_W-1:0] lo_len;
   logic [LEN_W-1:0] tgt;
   logic [LEN_W-1:0] el_next;
   logic [IDX_W-1:0] n_raw;
   logic [IDX_W-1:0] n_clamp;
   logic [4:0] nib_sel;
   logic lvl;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   sft_tick_gen u_tick (
      .sys_clk_in(sys_clk_in),
      .resetn_in(resetn_in),
      .div_in(st_q.timing[TIM_DIV_LSB +: DIV_W]),
      .tick_out(tick)
   );

   sft_crc u_crc (
      .data_in(st_q.snap.data),
      .count_in(st_q.snap.ndata),
      .crc_out(crc)
   );

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_be
         assign be_mask[8*b +: 8] = {8{avs_byteenable_in[b]}};
      end
   endgenerate

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   // one wait state: data are ready on the second cycle of a request
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~st_q.ack;
   assign wr_now = avs_write_in & st_q.ack;
   assign wmerge = avs_writedata_in & be_mask;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;

      // bus side
      st_d.ack = req & ~st_q.ack;
      if (req && !st_q.ack) begin
         case (avs_address_in)
            REG_CTRL: begin
               st_d.rdata = st_q.ctrl;
            end
            REG_TIMING: begin
               st_d.rdata = st_q.timing;
            end
            REG_FRAME: begin
               st_d.rdata = st_q.frame;
            end
            REG_DATA: begin
               st_d.rdata = st_q.data;
            end
            REG_STATUS: begin
               st_d.rdata = '0;
               st_d.rdata[STS_BUSY_BIT] = (st_q.state != ST_IDLE);
               st_d.rdata[STS_PEND_BIT] = st_q.pend;
               st_d.rdata[STS_LINE_BIT] = st_q.line;
               st_d.rdata[STS_FCNT_LSB +: 16] = st_q.fcnt;
            end
            default: begin
               st_d.rdata = '0;
            end
         endcase
      end
      if (wr_now) begin
         case (avs_address_in)
            REG_CTRL: begin
               st_d.ctrl = ((st_q.ctrl & ~be_mask) | wmerge) & CTRL_MASK;
            end
            REG_TIMING: begin
               st_d.timing = ((st_q.timing & ~be_mask) | wmerge) & TIM_MASK;
            end
            REG_FRAME: begin
               st_d.frame = ((st_q.frame & ~be_mask) | wmerge) & FRM_MASK;
            end
            REG_DATA: begin
               st_d.data = ((st_q.data & ~be_mask) | wmerge) & DATA_MASK;
            end
            default: begin
            end
         endcase
      end

      // trigger pin synchroniser and rising edge
      st_d.sy1 = trig_in;
      st_d.sy2 = st_q.sy1;
      st_d.sy3 = st_q.sy2;
      trig_edge = st_q.sy2 & ~st_q.sy3;
      if (wr_now && avs_address_in == REG_TRIG && wmerge[TRIG_BIT]) begin
         trig_edge = 1'b1;
      end

      // frame start decision
      can_start = (st_q.ctrl[CTRL_PROTO_LSB +: 2] == PROTO_SENT)
         && (!st_q.ctrl[CTRL_TRIG_BIT] || st_q.pend);

      // nibble geometry
      fix_eff = (st_q.snap.fixed == '0) ? LEN_W'(1) : LEN_W'(st_q.snap.fixed);
      nib_sel = 5'(NIB_W * (DATA_MAX - 1)) - {st_q.idx, 2'b00};
      case (st_q.state)
         ST_STAT: begin
            nib_val = {st_q.snap.serial, st_q.snap.status};
         end
         ST_DATA: begin
            nib_val = st_q.snap.data[nib_sel +: NIB_W];
         end
         ST_CRC: begin
            nib_val = crc;
         end
         default: begin
            nib_val = '0;
         end
      endcase
      case (st_q.state)
         ST_SYNC: begin
            tot = LEN_W'(SYNC_TICKS);
         end
         ST_PAUSE: begin
            tot = st_q.pause_len;
         end
         default: begin
            tot = fix_eff + LEN_W'(VAR_BASE) + LEN_W'(nib_val);
         end
      endcase
      // fixed interval low or high
      lo_len = st_q.snap.fixsel ? (tot - fix_eff) : fix_eff;
      last_tick = tick && (st_q.cnt == tot - LEN_W'(1));

      // padded frame length for constant-length mode
      tgt = LEN_W'(SYNC_TICKS + PAUSE_MIN)
         + LEN_W'((int'(st_q.snap.ndata) + 2) * (int'(fix_eff) + VAR_BASE + NIB_MAX))
         + fix_eff;
      el_next = st_q.elapsed + LEN_W'(1);

      // sequencer
      start_now = 1'b0;
      case (st_q.state)
         ST_IDLE: begin
            if (tick && can_start) begin
               start_now = 1'b1;
            end
         end
         ST_SYNC, ST_STAT, ST_DATA, ST_CRC, ST_PAUSE: begin
            if (tick) begin
               st_d.cnt = st_q.cnt + LEN_W'(1);
               if (st_q.state != ST_PAUSE) begin
                  st_d.elapsed = el_next;
               end
            end
            if (last_tick) begin
               st_d.cnt = '0;
               case (st_q.state)
                  ST_SYNC: begin
                     st_d.state = ST_STAT;
                  end
                  ST_STAT: begin
                     st_d.state = ST_DATA;
                     st_d.idx = '0;
                  end
                  ST_DATA: begin
                     if (st_q.idx == st_q.snap.ndata - IDX_W'(1)) begin
                        st_d.state = ST_CRC;
                     end else begin
                        st_d.idx = st_q.idx + IDX_W'(1);
                     end
                  end
                  ST_CRC: begin
                     if (st_q.snap.pause) begin
                        st_d.state = ST_PAUSE;
                        st_d.pause_len = tgt - el_next;
                     end else begin
                        st_d.state = ST_IDLE;
                        start_now = can_start;
                     end
                  end
                  default: begin
                     st_d.state = ST_IDLE;
                     start_now = can_start;
                  end
               endcase
               if (st_q.state == ST_CRC || st_q.state == ST_PAUSE) begin
                  st_d.fcnt = st_q.fcnt + 16'h0001;
               end
            end
         end
         default: begin
            st_d.state = ST_IDLE;
         end
      endcase

      // frame start: snapshot settings except the tick divider, which u_tick reads live from the timing register
      n_raw = st_q.frame[FRM_CNT_LSB +: IDX_W];
      if (n_raw < IDX_W'(DATA_MIN)) begin
         n_clamp = IDX_W'(DATA_MIN);
      end else if (n_raw > IDX_W'(DATA_MAX)) begin
         n_clamp = IDX_W'(DATA_MAX);
      end else begin
         n_clamp = n_raw;
      end
      if (start_now) begin
         st_d.state = ST_SYNC;
         st_d.cnt = '0;
         st_d.elapsed = '0;
         st_d.idx = '0;
         st_d.snap.invert = st_q.ctrl[CTRL_INV_BIT];
         st_d.snap.fixsel = st_q.ctrl[CTRL_FIXSEL_BIT];
         st_d.snap.pause = st_q.ctrl[CTRL_PAUSE_BIT];
         st_d.snap.fixed = st_q.timing[TIM_FIX_LSB +: 4];
         st_d.snap.ndata = n_clamp;
         st_d.snap.status = st_q.frame[FRM_STAT_LSB +: 2];
         st_d.snap.serial = st_q.frame[FRM_SER_LSB +: 2];
         st_d.snap.data = st_q.data[DATA_W-1:0];
      end

      // one pending frame; triggers before its start merge into it, a trigger in the start cycle is kept
      st_d.pend = trig_edge | (st_q.pend & ~(start_now & st_q.ctrl[CTRL_TRIG_BIT]));

      // line level, idle released high, or low when the invert option is set
      if (st_q.state == ST_IDLE) begin
         lvl = 1'b1 ^ st_q.ctrl[CTRL_INV_BIT];
      end else begin
         lvl = (st_q.cnt >= lo_len) ^ st_q.snap.invert;
      end
      st_d.line = lvl;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q <= '0;
         st_q.ctrl <= CTRL_RST;
         st_q.timing <= TIM_RST;
         st_q.frame <= FRM_RST;
         st_q.state <= ST_IDLE;
         st_q.line <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign avs_readdata_out = st_q.rdata;
   assign sent_out = st_q.line;
endmodule : sft_transmitter

// *** tb/sft_transmitter_assertions.sv ***
// concurrent checks on the nibble transmitter ports
// bound into every sft_transmitter instance
`timescale 1ns/1ps
module sft_transmitter_assertions
   import sft_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic sent_out
);
   logic req;
   logic ack;
   assign req = avs_read_in | avs_write_in;
   assign ack = avs_read_in & ~avs_waitrequest_out;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);
   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   chk_rd_first_wait: assert property ($rose(avs_read_in) |-> avs_waitrequest_out)
      else $error("read not stalled in its first cycle");
   chk_wr_first_wait: assert property ($rose(avs_write_in) |-> avs_waitrequest_out)
      else $error("write not stalled in its first cycle");
   chk_one_wait: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("more than one wait cycle");
   chk_idle_no_wait: assert property (!req |-> !avs_waitrequest_out)
      else $error("waitrequest high while idle");
   chk_rdata_hold: assert property (!req |=> $stable(avs_readdata_out))
      else $error("read data moved while idle");
   chk_unmapped_zero: assert property (ack && avs_address_in > REG_TRIG |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   chk_ctrl_resv: assert property (ack && avs_address_in == REG_CTRL |-> (avs_readdata_out & ~CTRL_MASK) == 32'h0)
      else $error("control reserved bits set");
   chk_tim_resv: assert property (ack && avs_address_in == REG_TIMING |-> (avs_readdata_out & ~TIM_MASK) == 32'h0)
      else $error("timing reserved bits set");
   // ------------------------------------------------------------
   // line
   // ------------------------------------------------------------
   chk_line_min: assert property ($changed(sent_out) |=> $stable(sent_out)[*8] ##1 $stable(sent_out))
      else $error("line level shorter than one tick");
   chk_reset_idle: assert property ($rose(resetn_in) |-> sent_out)
      else $error("line not idle high after reset");
   chk_auto_start: assert property ($rose(resetn_in) |-> ##[1:400] $fell(sent_out))
      else $error("no frame started after reset");
   cover property ($fell(sent_out));
   cover property (ack);
   cover property (avs_write_in && !avs_waitrequest_out);
endmodule : sft_transmitter_assertions

bind sft_transmitter sft_transmitter_assertions sft_transmitter_assertions_inst (
   .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .sent_out(sent_out));

// *** tb/sft_rx_model.sv ***
// receiver model for the single-wire nibble link
// measures fall-to-fall spans in system cycles; drives the trigger pin
`timescale 1ns/1ps
module sft_rx_model
   import sft_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic line_in,
   input wire logic inv_in,
   input wire logic [DIV_W-1:0] div_in,
   output logic trig_out
);
   int tot_q[$];
   int low_q[$];
   int n_sync = 0;
   int cnt = 0;
   int low = 0;
   logic armed = 1'b0;
   logic prev = 1'b1;
   logic lv;
   initial trig_out = 1'b0;
   // ------------------------------------------------------------
   // nibble capture
   // ------------------------------------------------------------
   always @(posedge sys_clk_in) begin
      lv = line_in ^ inv_in;
      if (!resetn_in) begin
         armed = 1'b0;
         cnt = 0;
         prev = 1'b1;
      end else begin
         if (prev && !lv) begin
            if (armed) begin
               tot_q.push_back(cnt);
               low_q.push_back(low);
               if (cnt == 56 * REF_DIV * div_in) n_sync++;
            end
            armed = 1'b1;
            cnt = 0;
            low = 0;
         end
         cnt++;
         if (!lv) low++;
         prev = lv;
      end
   end
   // ------------------------------------------------------------
   // trigger request
   // ------------------------------------------------------------
   task automatic fire();
      @(posedge sys_clk_in);
      trig_out <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      trig_out <= 1'b0;
   endtask : fire
endmodule : sft_rx_model

// *** tb/testbench.sv ***
// self-checking bench for the nibble transmitter
// frames are read back through the receiver model
`timescale 1ns/1ps
module testbench import sft_pkg::*;;
   typedef struct packed {logic [31:0] ctrl; logic [31:0] tim; logic [31:0] frm; logic [31:0] dat;
      logic [3:0] crc;} sft_row_t;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_rq;
   logic trig;
   logic line;
   logic inv = 1'b0;
   logic [DIV_W-1:0] div = 7'h0c;
   int fail_count = 0;
   int n_tests = 0;
   sft_row_t rows [6] = '{
      '{32'h0, 32'h0501, 32'h30, 32'h000000, 4'h9}, '{32'h0, 32'h0501, 32'h6e, 32'hfedcba, 4'he},
      '{32'h4, 32'h0301, 32'h41, 32'h123456, 4'he}, '{32'h8, 32'h0501, 32'h55, 32'h9a5c3f, 4'h3},
      '{32'h2, 32'h0c01, 32'h32, 32'hf0f000, 4'h6}, '{32'h0, 32'h0502, 32'h60, 32'h5a5a5a, 4'h6}};
   always #12.5 sys_clk = ~sys_clk;
   sft_transmitter sft_transmitter_inst (.sys_clk_in(sys_clk), .resetn_in(resetn), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq), .trig_in(trig), .sent_out(line));
   sft_rx_model sft_rx_model_inst (.sys_clk_in(sys_clk), .resetn_in(resetn), .line_in(line), .inv_in(inv),
      .div_in(div), .trig_out(trig));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do @(posedge sys_clk); while (wait_rq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask : cmp_w
   task automatic cmp_i(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         fail_count++;
         $display("MISMATCH %0t span %0d expected %0d", $time, got, exp);
      end
   endtask : cmp_i
   task automatic next_nib(output int t, output int l);
      while (sft_rx_model_inst.tot_q.size() == 0) @(posedge sys_clk);
      t = sft_rx_model_inst.tot_q.pop_front();
      l = sft_rx_model_inst.low_q.pop_front();
   endtask : next_nib
   function automatic logic [3:0] crc_of(input logic [23:0] d, input int n);
      logic [4:0] c;
      c = 5'h05;
      for (int i = 0; i <= n; i++) begin
         for (int b = 0; b < 4; b++) begin
            c = c << 1;
            if (c[4]) c = c ^ 5'h1d;
         end
         if (i < n) c[3:0] = c[3:0] ^ d[23-4*i -: 4];
      end
      return c[3:0];
   endfunction : crc_of
   task automatic wait_busy(input logic v);
      logic [31:0] q;
      do bus(1'b0, REG_STATUS, 32'h0, q); while (q[STS_BUSY_BIT] !== v);
   endtask : wait_busy
   task automatic check_frame(input sft_row_t r);
      int tk, f, n, t, l, sum;
      logic [3:0] v;
      tk = REF_DIV * int'(r.tim[6:0]);
      f = r.tim[11:8];
      n = r.frm[6:4];
      cmp_w(32'(crc_of(r.dat[23:0], n)), 32'(r.crc));
      for (int s = 0; s < 2; s++) do next_nib(t, l); while (t != 56 * tk);
      cmp_i(l, (r.ctrl[2] ? 56 - f : f) * tk);
      sum = 56;
      for (int k = 0; k <= n + 1; k++) begin
         v = (k == 0) ? r.frm[3:0] : (k <= n) ? r.dat[27-4*k -: 4] : r.crc;
         next_nib(t, l);
         cmp_i(t, (f + 7 + v) * tk);
         cmp_i(l, (r.ctrl[2] ? 7 + v : f) * tk);
         sum += f + 7 + v;
      end
      if (r.ctrl[3]) begin
         next_nib(t, l);
         cmp_i(t, (68 + (n + 2) * (f + 22) + f - sum) * tk);
      end
      next_nib(t, l);
      cmp_i(t, 56 * tk);
   endtask : check_frame
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] q;
      int s0;
      repeat (5) @(posedge sys_clk);
      cmp_w({31'h0, line}, 32'h1);
      resetn <= 1'b1;
      bus(1'b0, REG_TIMING, 32'h0, q);
      cmp_w(q, TIM_RST);
      bus(1'b1, REG_TIMING, 32'h0501, q);
      bus(1'b0, REG_CTRL, 32'h0, q);
      cmp_w(q, CTRL_RST);
      bus(1'b0, REG_FRAME, 32'h0, q);
      cmp_w(q, FRM_RST);
      $display("test reset done");
      foreach (rows[i]) begin
         bus(1'b1, REG_CTRL, rows[i].ctrl, q);
         bus(1'b1, REG_TIMING, rows[i].tim, q);
         bus(1'b1, REG_FRAME, rows[i].frm, q);
         bus(1'b1, REG_DATA, rows[i].dat, q);
         div <= rows[i].tim[6:0];
         inv <= rows[i].ctrl[1];
         check_frame(rows[i]);
         $display("test frame row %0d done", i);
      end
      bus(1'b1, 8'h18, 32'hffff_ffff, q);
      bus(1'b0, 8'h18, 32'h0, q);
      cmp_w(q, 32'h0);
      $display("test unmapped done");
      bus(1'b1, REG_CTRL, 32'h10, q);
      wait_busy(1'b0);
      s0 = sft_rx_model_inst.n_sync;
      repeat (2000) @(posedge sys_clk);
      cmp_i(sft_rx_model_inst.n_sync, s0);
      cmp_w({31'h0, line}, 32'h1);
      $display("test protocol done");
      bus(1'b1, REG_CTRL, 32'h1, q);
      wait_busy(1'b0);
      cmp_w({31'h0, line}, 32'h1);
      s0 = sft_rx_model_inst.n_sync;
      sft_rx_model_inst.fire();
      wait_busy(1'b1);
      wait_busy(1'b0);
      cmp_i(sft_rx_model_inst.n_sync, s0 + 1);
      bus(1'b1, REG_TRIG, 32'h1, q);
      wait_busy(1'b1);
      wait_busy(1'b0);
      cmp_i(sft_rx_model_inst.n_sync, s0 + 2);
      $display("test trigger done");
      finish_test();
   end
   initial begin
      repeat (100000) @(posedge sys_clk);
      fail_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      finish_test();
   end
endmodule : testbench
